//--- por_sleep_pkg.sv
// Shared constants for the power-on delay and sleep-mode controller
package por_sleep_pkg;

   // Power-on delay, least time, in milliseconds as printed
   localparam real POR_MIN_MS = 2.5;
   // System clock rate in megahertz
   localparam real MCLK_MHZ = 50.0;
   // Least delay in system clock cycles, rounded up
   localparam int POR_MIN_CYCLES = int'($ceil(POR_MIN_MS * 1000.0 * MCLK_MHZ));
   // System clock cycles per tick of the delay oscillator
   localparam int RC_DIV_DEFAULT = 50;

   // Restart address after leaving stop mode through a reset
   localparam logic [15:0] STOP_RESTART_ADDR = 16'h000c;
   // Restart address after a cold start
   localparam logic [15:0] COLD_RESTART_ADDR = 16'h0000;

   // Number of external interrupt request inputs
   localparam int NUM_EXT_IRQ = 6;
   // Flip-flop stages of each pin synchroniser
   localparam int SYNC_STAGES = 2;

   // Controller states
   typedef enum logic [2:0] {
      ST_PWRWAIT,
      ST_DELAY,
      ST_EXTRST,
      ST_RUN,
      ST_HALT,
      ST_STOP
   } pwr_state_e;

endpackage : por_sleep_pkg

//--- por_oneshot_timer.sv
// One-shot power-on delay timer ticked by its own oscillator divider
`timescale 1ns/1ns
module por_oneshot_timer
   import por_sleep_pkg::*;
#(
   parameter int RC_DIV = RC_DIV_DEFAULT,
   parameter int TICKS = 2500
)
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_start,
   output logic o_busy,
   output logic o_done
);

   localparam int DIV_W = (RC_DIV > 2) ? $clog2(RC_DIV) : 1;
   localparam int TICK_W = $clog2(TICKS + 1);
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(RC_DIV - 1);
   localparam logic [TICK_W-1:0] TICK_LOAD = TICK_W'(TICKS);
   localparam logic [TICK_W-1:0] TICK_ONE = TICK_W'(1);

   logic [DIV_W-1:0] div_reg; // Oscillator divider phase
   logic [DIV_W-1:0] div_next;
   logic [TICK_W-1:0] tick_reg; // Ticks still to run
   logic [TICK_W-1:0] tick_next;
   logic busy_reg; // Delay running
   logic busy_next;
   logic done_reg; // Delay finished, one cycle
   logic done_next;
   logic rc_tick; // One-cycle oscillator tick enable

   ////////////////////////////////////////////////////////////////////////////
   // Next state: a start restarts the oscillator phase and reloads the count
   always_comb
   begin
      div_next = div_reg;
      tick_next = tick_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      rc_tick = busy_reg && (div_reg == DIV_LAST);
      if (i_start)
      begin
         // Retrigger always restarts the full delay
         div_next = '0;
         tick_next = TICK_LOAD;
         busy_next = 1'b1;
      end
      else if (busy_reg)
      begin
         // Timer advances only on oscillator ticks
         div_next = rc_tick ? '0 : div_reg + DIV_W'(1);
         if (rc_tick)
         begin
            tick_next = tick_reg - TICK_ONE;
            if (tick_reg == TICK_ONE)
            begin
               busy_next = 1'b0;
               done_next = 1'b1;
            end
         end
      end
   end

   // Registers only
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         div_reg <= '0;
         tick_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         div_reg <= div_next;
         tick_reg <= tick_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign o_busy = busy_reg;
   assign o_done = done_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Helper: cycles since the last start, for the duration check
   logic [31:0] run_cnt_reg;
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         run_cnt_reg <= '0;
      end
      else
      begin
         run_cnt_reg <= i_start ? 32'h0000_0000 : run_cnt_reg + 32'h0000_0001;
      end
   end

   property p_delay_length;
      @(posedge i_mclk) disable iff (!i_rst_b)
      $fell(busy_reg) |-> run_cnt_reg == 32'(RC_DIV * TICKS);
   endproperty
   a_delay_length: assert property (p_delay_length)
      else $error("Delay ended after the wrong number of cycles");

   property p_done_with_fall;
      @(posedge i_mclk) disable iff (!i_rst_b)
      done_reg |-> !busy_reg && $past(busy_reg);
   endproperty
   a_done_with_fall: assert property (p_done_with_fall)
      else $error("Done pulse without a running delay");

endmodule : por_oneshot_timer

//--- por_sleep_ctrl.sv
// Power-on delay, reset release and halt/stop clock control
`timescale 1ns/1ns
module por_sleep_ctrl
   import por_sleep_pkg::*;
#(
   parameter int POR_CYCLES = POR_MIN_CYCLES,
   parameter int RC_DIV = RC_DIV_DEFAULT
)
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_power_ok,
   input wire logic i_ext_reset_b,
   input wire logic i_stop_recovery,
   input wire logic [NUM_EXT_IRQ-1:0] i_irq,
   input wire logic [NUM_EXT_IRQ-1:0] i_irq_enable,
   input wire logic i_int_irq,
   input wire logic i_wdt_timeout,
   input wire logic i_recovery_delay_en,
   input wire logic i_halt_req,
   input wire logic i_stop_req,
   output logic o_cpu_rst_b,
   output logic o_cpu_clk_en,
   output logic o_xtal_en,
   output logic o_periph_clk_en,
   output logic o_por_busy,
   output logic [15:0] o_restart_addr
);

   // Ticks of the delay oscillator, rounded up to cover the least time
   localparam int POR_TICKS = (POR_CYCLES + RC_DIV - 1) / RC_DIV;
   localparam int PIN_W = NUM_EXT_IRQ + 3;
   // Every check in this module runs on the system clock and is off in reset
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PIN_W-1:0] pin_meta_reg; // First stage, read only by the second
   logic [PIN_W-1:0] pin_sync_reg; // Second stage, safe to use
   logic pwr_ok_s; // Supply good
   logic ext_rst_b_s; // External reset pin, low active
   logic recov_s; // Stop-mode recovery request
   logic [NUM_EXT_IRQ-1:0] irq_s; // External interrupt requests

   // Two flip-flops per pin
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         pin_meta_reg <= '0;
         pin_sync_reg <= '0;
      end
      else
      begin
         pin_meta_reg <= {i_stop_recovery, i_ext_reset_b, i_power_ok, i_irq};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign irq_s = pin_sync_reg[NUM_EXT_IRQ-1:0];
   assign pwr_ok_s = pin_sync_reg[NUM_EXT_IRQ];
   assign ext_rst_b_s = pin_sync_reg[NUM_EXT_IRQ+1];
   assign recov_s = pin_sync_reg[NUM_EXT_IRQ+2];

   ////////////////////////////////////////////////////////////////////////////
   // Delay timer
   logic por_start; // Launch the one-shot
   logic por_done; // One-shot finished

   por_oneshot_timer #(
      .RC_DIV(RC_DIV),
      .TICKS(POR_TICKS)
   ) u_timer (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_start(por_start),
      .o_busy(o_por_busy),
      .o_done(por_done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Controller state and registered outputs
   pwr_state_e state_reg;
   pwr_state_e state_next;
   logic cpu_rst_b_reg;
   logic cpu_rst_b_next;
   logic cpu_clk_en_reg;
   logic cpu_clk_en_next;
   logic xtal_en_reg;
   logic xtal_en_next;
   logic periph_en_reg;
   logic periph_en_next;
   logic [15:0] addr_reg;
   logic [15:0] addr_next;
   logic wake; // Enabled interrupt pending

   // Enabled external interrupt, or any internal interrupt, wakes from halt
   assign wake = (|(irq_s & i_irq_enable)) || i_int_irq;

   // Next state and outputs
   always_comb
   begin
      state_next = state_reg;
      por_start = 1'b0;
      addr_next = addr_reg;
      if (!pwr_ok_s)
      begin
         // Supply lost: hold everything until power is good again
         state_next = ST_PWRWAIT;
         addr_next = COLD_RESTART_ADDR;
      end
      else if (state_reg == ST_PWRWAIT)
      begin
         // Power became good, including brownout wake
         state_next = ST_DELAY;
         por_start = 1'b1;
      end
      else if (!ext_rst_b_s)
      begin
         // External reset, also ends stop
         state_next = ST_EXTRST;
         if (state_reg == ST_STOP)
            addr_next = STOP_RESTART_ADDR;
      end
      else if (i_wdt_timeout)
      begin
         // Watchdog expiry restarts the delay
         state_next = ST_DELAY;
         por_start = 1'b1;
         if (state_reg == ST_STOP)
            addr_next = STOP_RESTART_ADDR;
      end
      else
      begin
         unique case (state_reg)
            // Not reached here: power-wait is handled above
            ST_PWRWAIT: state_next = ST_DELAY;
            ST_DELAY:
            begin
               // Execution waits for the delay to finish
               if (por_done)
                  state_next = ST_RUN;
            end
            // Pin released; a delay that the pin cut into still runs out first
            ST_EXTRST: state_next = o_por_busy ? ST_DELAY : ST_RUN;
            ST_RUN:
            begin
               // Stop takes priority over halt
               if (i_stop_req)
                  state_next = ST_STOP;
               else if (i_halt_req)
                  state_next = ST_HALT;
            end
            ST_HALT:
            begin
               // Only an enabled external or any internal interrupt resumes the core
               if (wake)
                  state_next = ST_RUN;
            end
            ST_STOP:
            begin
               // Interrupts are ignored; in this branch only recovery leaves, reset causes are handled above
               if (recov_s)
               begin
                  addr_next = STOP_RESTART_ADDR;
                  if (i_recovery_delay_en)
                  begin
                     state_next = ST_DELAY;
                     por_start = 1'b1;
                  end
                  else
                     state_next = ST_EXTRST;
               end
            end
         endcase
      end
      // Outputs follow the next state
      cpu_rst_b_next = (state_next == ST_RUN) || (state_next == ST_HALT)
         || (state_next == ST_STOP);
      cpu_clk_en_next = (state_next != ST_HALT) && (state_next != ST_STOP);
      xtal_en_next = (state_next != ST_STOP);
      periph_en_next = (state_next != ST_STOP);
   end

   // Registers only
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg <= ST_PWRWAIT;
         cpu_rst_b_reg <= 1'b0;
         cpu_clk_en_reg <= 1'b1;
         xtal_en_reg <= 1'b1;
         periph_en_reg <= 1'b1;
         addr_reg <= COLD_RESTART_ADDR;
      end
      else
      begin
         state_reg <= state_next;
         cpu_rst_b_reg <= cpu_rst_b_next;
         cpu_clk_en_reg <= cpu_clk_en_next;
         xtal_en_reg <= xtal_en_next;
         periph_en_reg <= periph_en_next;
         addr_reg <= addr_next;
      end
   end

   assign o_cpu_rst_b = cpu_rst_b_reg;
   assign o_cpu_clk_en = cpu_clk_en_reg;
   assign o_xtal_en = xtal_en_reg;
   assign o_periph_clk_en = periph_en_reg;
   assign o_restart_addr = addr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic quiet; // No reset cause this cycle
   assign quiet = pwr_ok_s && ext_rst_b_s && !i_wdt_timeout;

   property p_wdt_launch;
      (state_reg == ST_RUN && pwr_ok_s && ext_rst_b_s && i_wdt_timeout)
         |=> o_por_busy && !o_cpu_rst_b;
   endproperty
   a_wdt_launch: assert property (p_wdt_launch)
      else $error("Watchdog expiry did not launch the delay");

   property p_hold_in_delay;
      o_por_busy |-> !o_cpu_rst_b;
   endproperty
   a_hold_in_delay: assert property (p_hold_in_delay)
      else $error("Execution released during the delay");

   property p_recov_delay;
      (state_reg == ST_STOP && quiet && recov_s && i_recovery_delay_en) |=> o_por_busy [*2];
   endproperty
   a_recov_delay: assert property (p_recov_delay)
      else $error("Recovery with delay bit set skipped the delay");

   property p_recov_bypass;
      (state_reg == ST_STOP && quiet && recov_s && !i_recovery_delay_en)
         |=> !o_por_busy && !o_cpu_rst_b ##1 (o_cpu_rst_b || !$past(quiet));
   endproperty
   a_recov_bypass: assert property (p_recov_bypass)
      else $error("Recovery with delay bit clear did not bypass the delay");

   property p_halt_clocks;
      (state_reg == ST_HALT) |-> !o_cpu_clk_en && o_xtal_en && o_periph_clk_en;
   endproperty
   a_halt_clocks: assert property (p_halt_clocks)
      else $error("Wrong clock gating in halt");

   property p_halt_wake;
      (state_reg == ST_HALT && quiet) |=> (o_cpu_clk_en == $past(wake)) && o_cpu_rst_b;
   endproperty
   a_halt_wake: assert property (p_halt_wake)
      else $error("Halt exit does not match pending interrupt");

   property p_stop_clocks;
      (state_reg == ST_STOP) |-> !o_cpu_clk_en && !o_xtal_en && !o_periph_clk_en;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks)
      else $error("A clock runs in stop");

   property p_stop_hold;
      (state_reg == ST_STOP && quiet && !recov_s) |=> state_reg == ST_STOP;
   endproperty
   a_stop_hold: assert property (p_stop_hold)
      else $error("Stop left without a reset source");

   property p_stop_addr;
      (state_reg == ST_STOP && pwr_ok_s && (!ext_rst_b_s || i_wdt_timeout || recov_s))
         |=> o_restart_addr == STOP_RESTART_ADDR && !o_cpu_rst_b;
   endproperty
   a_stop_addr: assert property (p_stop_addr)
      else $error("Stop exit without restart address");

   property p_release;
      (por_done && state_reg == ST_DELAY && quiet) |=> o_cpu_rst_b;
   endproperty
   a_release: assert property (p_release)
      else $error("Reset not released after the delay");

endmodule : por_sleep_ctrl

//--- core_sleep_model.sv
// Processor core model that issues sleep instructions on command
`timescale 1ns/1ns
module core_sleep_model
   import por_sleep_pkg::*;
#(
   parameter logic [7:0] NOP_OP = 8'hff,
   // Halt and stop opcodes: values arbitrary
   parameter logic [7:0] HALT_OP = 8'h11,
   parameter logic [7:0] STOP_OP = 8'h22
)
(
   input wire logic i_mclk,
   input wire logic i_cpu_rst_b,
   input wire logic i_cpu_clk_en,
   input wire logic i_halt_cmd,
   input wire logic i_stop_cmd,
   output logic [7:0] o_opcode,
   output logic o_halt_req,
   output logic o_stop_req
);
   // Pending sleep kind: bit 0 halt, bit 1 stop
   logic [1:0] pend = 2'h0;

   initial
   begin
      o_opcode = 8'h00;
      o_halt_req = 1'b0;
      o_stop_req = 1'b0;
   end

   // Executes only with its clock enabled and reset released
   always @(posedge i_mclk)
   begin
      o_halt_req <= 1'b0;
      o_stop_req <= 1'b0;
      if (i_cpu_rst_b !== 1'b1)
         pend <= 2'h0;
      else if (i_cpu_clk_en === 1'b1 && pend != 2'h0)
      begin
         // Sleep instruction follows the no-op
         o_opcode <= pend[1] ? STOP_OP : HALT_OP;
         o_halt_req <= pend[0];
         o_stop_req <= pend[1];
         pend <= 2'h0;
      end
      else if (i_cpu_clk_en === 1'b1 && (i_halt_cmd | i_stop_cmd))
      begin
         // Pipeline flush no-op first
         o_opcode <= NOP_OP;
         pend <= {i_stop_cmd, i_halt_cmd & ~i_stop_cmd};
      end
   end
endmodule : core_sleep_model

//--- test_por_sleep_ctrl.sv
// Testbench for the power-on delay and sleep-mode controller
`timescale 1ns/1ns
module test_por_sleep_ctrl
   import por_sleep_pkg::*;
;
   localparam int POR_T = 200;
   localparam int DIV_T = 4;
   // Expected busy length in cycles
   localparam int BUSY_T = DIV_T * ((POR_T + DIV_T - 1) / DIV_T);

   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_power_ok = 1'b1;
   logic i_ext_reset_b = 1'b1;
   logic i_stop_recovery = 1'b0;
   logic [NUM_EXT_IRQ-1:0] i_irq = 6'h00;
   logic [NUM_EXT_IRQ-1:0] i_irq_enable = 6'h00;
   logic i_int_irq = 1'b0;
   logic i_wdt_timeout = 1'b0;
   logic i_recovery_delay_en = 1'b0;
   logic halt_cmd = 1'b0;
   logic stop_cmd = 1'b0;
   logic halt_req;
   logic stop_req;
   logic o_cpu_rst_b;
   logic o_cpu_clk_en;
   logic o_xtal_en;
   logic o_periph_clk_en;
   logic o_por_busy;
   logic [15:0] o_restart_addr;
   int miscompares = 0;
   int checks_done = 0;

   por_sleep_ctrl #(.POR_CYCLES(POR_T), .RC_DIV(DIV_T)) dut_u (.i_mclk(i_mclk),
      .i_rst_b(i_rst_b), .i_power_ok(i_power_ok), .i_ext_reset_b(i_ext_reset_b),
      .i_stop_recovery(i_stop_recovery), .i_irq(i_irq), .i_irq_enable(i_irq_enable),
      .i_int_irq(i_int_irq), .i_wdt_timeout(i_wdt_timeout),
      .i_recovery_delay_en(i_recovery_delay_en), .i_halt_req(halt_req),
      .i_stop_req(stop_req), .o_cpu_rst_b(o_cpu_rst_b), .o_cpu_clk_en(o_cpu_clk_en),
      .o_xtal_en(o_xtal_en), .o_periph_clk_en(o_periph_clk_en),
      .o_por_busy(o_por_busy), .o_restart_addr(o_restart_addr));

   core_sleep_model core_u (.i_mclk(i_mclk), .i_cpu_rst_b(o_cpu_rst_b),
      .i_cpu_clk_en(o_cpu_clk_en), .i_halt_cmd(halt_cmd), .i_stop_cmd(stop_cmd),
      .o_opcode(), .o_halt_req(halt_req), .o_stop_req(stop_req));

   // 50 MHz clock
   initial
   begin
      forever #10 i_mclk = ~i_mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask : cyc

   // One-cycle pulse: 0 watchdog, 1 recovery pin, 2 halt, 3 stop
   task automatic pulse(input int which);
      i_wdt_timeout = (which == 0);
      i_stop_recovery = (which == 1);
      halt_cmd = (which == 2);
      stop_cmd = (which == 3);
      cyc(1);
      i_wdt_timeout = 1'b0;
      i_stop_recovery = 1'b0;
      halt_cmd = 1'b0;
      stop_cmd = 1'b0;
   endtask : pulse

   task automatic wait_clk_en(input logic v);
      int w;
      w = 0;
      while (o_cpu_clk_en !== v && w < 20)
      begin
         cyc(1);
         w++;
      end
   endtask : wait_clk_en

   // Measures the busy span and the core reset around it
   task automatic delay_check(input logic [15:0] addr);
      int n;
      int w;
      logic held;
      n = 0;
      w = 0;
      held = 1'b1;
      while (o_por_busy !== 1'b1 && w < 20)
      begin
         cyc(1);
         w++;
      end
      while (o_por_busy === 1'b1 && n < 1000)
      begin
         held = held & (o_cpu_rst_b === 1'b0);
         cyc(1);
         n++;
      end
      check("delay length", n[15:0], BUSY_T[15:0]);
      check("reset held in delay", {15'h0000, held}, 16'h0001);
      check("reset at busy fall", {15'h0000, o_cpu_rst_b}, 16'h0000);
      cyc(1);
      check("reset released", {15'h0000, o_cpu_rst_b}, 16'h0001);
      check("restart address", o_restart_addr, addr);
   endtask : delay_check

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   // Power-up, then power loss and return
   task automatic t_power();
      delay_check(COLD_RESTART_ADDR);
      i_power_ok = 1'b0;
      cyc(6);
      check("reset on power loss", {15'h0000, o_cpu_rst_b}, 16'h0000);
      i_power_ok = 1'b1;
      delay_check(COLD_RESTART_ADDR);
   endtask : t_power

   // Watchdog in run, retriggered in mid-delay
   task automatic t_watchdog();
      pulse(0);
      cyc(50);
      pulse(0);
      delay_check(COLD_RESTART_ADDR);
   endtask : t_watchdog

   // Halt, ignore a disabled request, wake by external or internal one
   task automatic t_halt(input int kind);
      pulse(2);
      wait_clk_en(1'b0);
      check("halt clock", {15'h0000, o_cpu_clk_en}, 16'h0000);
      check("halt crystal", {15'h0000, o_xtal_en}, 16'h0001);
      check("halt peripherals", {15'h0000, o_periph_clk_en}, 16'h0001);
      i_irq = 6'h04;
      cyc(6);
      check("disabled wake", {15'h0000, o_cpu_clk_en}, 16'h0000);
      if (kind == 0)
         i_irq_enable = 6'h04;
      else
         i_int_irq = 1'b1;
      wait_clk_en(1'b1);
      check("halt wake", {15'h0000, o_cpu_clk_en}, 16'h0001);
      check("no reset on wake", {o_por_busy, 14'h0000, o_cpu_rst_b}, 16'h0001);
      i_irq = 6'h00;
      i_irq_enable = 6'h00;
      i_int_irq = 1'b0;
      cyc(2);
   endtask : t_halt

   // Stop, ignore interrupts, leave by recovery pin, watchdog or external reset
   task automatic t_stop(input int mode);
      logic dip;
      dip = 1'b0;
      i_recovery_delay_en = (mode == 1);
      pulse(3);
      wait_clk_en(1'b0);
      check("stop crystal", {15'h0000, o_xtal_en}, 16'h0000);
      check("stop peripherals", {15'h0000, o_periph_clk_en}, 16'h0000);
      i_irq_enable = 6'h3f;
      i_irq = 6'h01;
      cyc(6);
      check("stop ignores irq", {15'h0000, o_cpu_clk_en}, 16'h0000);
      i_irq = 6'h00;
      i_irq_enable = 6'h00;
      if (mode == 3)
      begin
         i_ext_reset_b = 1'b0;
         cyc(6);
         check("ext reset held", {15'h0000, o_cpu_rst_b}, 16'h0000);
         check("ext reset clocks", {15'h0000, o_xtal_en}, 16'h0001);
         i_ext_reset_b = 1'b1;
         cyc(6);
         check("ext reset release", {o_por_busy, 14'h0000, o_cpu_rst_b}, 16'h0001);
         check("ext restart", o_restart_addr, STOP_RESTART_ADDR);
      end
      else if (mode == 0)
      begin
         pulse(1);
         repeat (10)
         begin
            dip = dip | (o_cpu_rst_b === 1'b0);
            check("bypass busy", {15'h0000, o_por_busy}, 16'h0000);
            cyc(1);
         end
         check("bypass reset pulse", {15'h0000, dip}, 16'h0001);
         check("bypass run", {o_cpu_clk_en, 14'h0000, o_cpu_rst_b}, 16'h8001);
         check("bypass restart", o_restart_addr, STOP_RESTART_ADDR);
      end
      else
      begin
         pulse(mode == 1 ? 1 : 0);
         delay_check(STOP_RESTART_ADDR);
      end
      cyc(2);
   endtask : t_stop

   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic finish_test();
      if (miscompares == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test

   // Main sequence
   initial
   begin
      cyc(10);
      i_rst_b = 1'b1;
      t_power();
      t_watchdog();
      t_halt(0);
      t_halt(1);
      for (int m = 0; m < 4; m++)
         t_stop(m);
      finish_test();
   end

   // Hang guard, about eight times the expected run
   initial
   begin
      #200000;
      miscompares++;
      finish_test();
   end
endmodule : test_por_sleep_ctrl
